// File: inc/bmc_consts.svh
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH
// Clock period and documented times.
`define BMC_CLK_NS 100
`define BMC_SCAN_ON_US 5000
`define BMC_SCAN_PERIOD_US 640000
`define BMC_SETTLE_US 1000
// Register indices; the byte address is four times the index.
`define BMC_IDX_MONSEL 6'h03
`define BMC_IDX_CTRL 6'h04
`define BMC_IDX_FEAT 6'h07
`define BMC_IDX_WREN 6'h08
`define BMC_IDX_STAT 6'h09
// Reset value of every register.
`define BMC_REG_RST 8'h00
// Control register bits.
`define BMC_CTRL_SLEEP 7
// Feature register bits and writable mask.
`define BMC_FEAT_ASD 7
`define BMC_FEAT_REGDIS 6
`define BMC_FEAT_FORCE 5
`define BMC_FEAT_POR 2
`define BMC_FEAT_WKDIS 1
`define BMC_FEAT_WAKE_EDGE_SELECT 0
`define BMC_FEAT_MASK 8'he3
// Write enable register bits and writable mask; user flags at 4,3,1,0.
`define BMC_WREN_FEATEN 7
`define BMC_WREN_MASK 8'h9b
// Monitor select code of the external temperature.
`define BMC_MON_EXT 4'h8
`endif

// File: inc/bmc_pkg.sv
/*
 Types shared by the battery monitor control block.
 Assumes the constants header is compiled alongside.
*/
package bmc_pkg;
	typedef enum logic [1:0] {ST_OFF, ST_AWAKE, ST_SLEEP} bmc_state_t;
	typedef struct packed {
		logic [7:0] rx_byte;
		logic bus_active;
		logic int_ot;
		logic ext_ot;
		logic awake;
	} bmc_stat_t;
	typedef struct packed {
		logic scl;
		logic sda;
		logic wake;
		logic therm_low;
		logic int_hot;
		logic supply_ok;
	} bmc_pins_t;
endpackage

// File: verilog/bmc_control.sv
/*
 Battery monitor control: power sequencing, wake pin, temperature scan,
 monitor select, user flags, APB registers and two-wire bus framing.
 Assumes analog comparators deliver digital levels on pins, asynchronous to pclk.
*/
// Overview of operation
// - Wake and regulator on only when supplies ok.
// - Stay awake until sleep command or supply loss.
// - Wake edge select picks falling or rising wake.
// - Auto scan powers sensor 5ms every 640ms.
// - After 1ms compare thermistor, flag low as fail.
// - External select keeps sensor on, routes thermistor.
// - Scan disable bit stops periodic scan only.
// - Force-on bit holds sensor supply on while awake.
// - Four-bit select steers the monitor output.
// - Four user flags, kept through sleep.
// - Forced power-on reset clears user flags.
// - Device is bus slave; master clocks everything.
// - Bytes shift most significant bit first.
// - Data changes only while clock is low.
// - Ignore bus until a start condition.
// - Stop ends transfer, returns to standby.
// - Force sleep self-clears on wake, select kept.
// - Scan disable is feature register bit 7.
// - Forced power-on reset zeroes all writable registers.
`timescale 1ns/1ps
`include "bmc_consts.svh"

module bmc_control
	import bmc_pkg::*;
#(
	parameter int SCAN_ON_CYC = `BMC_SCAN_ON_US * 1000 / `BMC_CLK_NS,
	parameter int SCAN_PERIOD_CYC = `BMC_SCAN_PERIOD_US * 1000 / `BMC_CLK_NS,
	parameter int SETTLE_CYC = `BMC_SETTLE_US * 1000 / `BMC_CLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cells_ok,
	input wire logic wake_pin,
	input wire logic thermistor_low,
	input wire logic internal_hot,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic regulator_output,
	output logic sensor_supply_out,
	output logic thermistor_route,
	output logic [3:0] monitor_select,
	output logic ext_ot_fail,
	output logic int_ot_fail,
	output logic [7:0] rx_byte,
	output logic bus_active
);

	function automatic logic bmc_hit(input logic [7:0] a, input logic [5:0] idx);
		bmc_hit = (a[7:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	localparam logic [22:0] ON_CYC = 23'(SCAN_ON_CYC);
	localparam logic [22:0] PERIOD_CYC = 23'(SCAN_PERIOD_CYC);
	localparam logic [22:0] SETTLE = 23'(SETTLE_CYC);

	bmc_pins_t pins_a;
	bmc_pins_t pins_b;
	bmc_pins_t pins_c;
	bmc_state_t state;
	bmc_state_t next_state;
	bmc_stat_t stat;
	logic [7:0] ctrl;
	logic [7:0] feat;
	logic [7:0] wren;
	logic [3:0] mon_sel;
	logic por_q;
	logic [22:0] period_cnt;
	logic [22:0] settle_cnt;
	logic [7:0] shift;
	logic [3:0] bit_cnt;

	// Pin synchronisers: first stage feeds only the second.
	wire bmc_pins_t pins_raw = '{scl: scl_in, sda: sda_in, wake: wake_pin,
		therm_low: thermistor_low, int_hot: internal_hot, supply_ok: cells_ok};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_a <= '0;
			pins_b <= '0;
			pins_c <= '0;
		end else if (ce) begin
			pins_a <= pins_raw;
			pins_b <= pins_a;
			pins_c <= pins_b;
		end
	end

	// APB decode.
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready & pwrite;
	wire hit_mon = bmc_hit(paddr, `BMC_IDX_MONSEL);
	wire hit_ctl = bmc_hit(paddr, `BMC_IDX_CTRL);
	wire hit_feat = bmc_hit(paddr, `BMC_IDX_FEAT);
	wire hit_wren = bmc_hit(paddr, `BMC_IDX_WREN);
	wire hit_stat = bmc_hit(paddr, `BMC_IDX_STAT);
	wire mapped = hit_mon | hit_ctl | hit_feat | hit_wren | hit_stat;
	wire feat_wr = wr & hit_feat & wren[`BMC_WREN_FEATEN];
	wire por_req = feat_wr & pwdata[`BMC_FEAT_POR];
	wire sleep_set = wr & hit_ctl & pwdata[`BMC_CTRL_SLEEP];
	wire [31:0] next_prdata = hit_mon ? {28'h0, mon_sel} :
		hit_ctl ? {24'h0, ctrl} :
		hit_feat ? {24'h0, feat} :
		hit_wren ? {24'h0, wren} :
		hit_stat ? {20'h0, stat} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= setup ? next_prdata : 32'h0;
		end
	end

	// Power state: supplies gate waking, sleep command and wake pin.
	wire ok = pins_b.supply_ok;
	wire wake_rise = pins_b.wake & ~pins_c.wake;
	wire wake_fall = ~pins_b.wake & pins_c.wake;
	wire wake_evt = (feat[`BMC_FEAT_WAKE_EDGE_SELECT] ? wake_rise : wake_fall) & ~feat[`BMC_FEAT_WKDIS];
	wire clr = por_q | (state == ST_OFF);
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (ok) next_state = ST_AWAKE;
			end
			ST_AWAKE: begin
				if (!ok) next_state = ST_OFF;
				else if (ctrl[`BMC_CTRL_SLEEP]) next_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (!ok) next_state = ST_OFF;
				else if (wake_evt) next_state = ST_AWAKE;
			end
			default: next_state = ST_OFF;
		endcase
	end
	wire awake_next = (next_state == ST_AWAKE);
	wire waking = (state == ST_SLEEP) & awake_next;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_OFF;
			por_q <= 1'b0;
			regulator_output <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			por_q <= por_req;
			regulator_output <= awake_next & ~feat[`BMC_FEAT_REGDIS];
		end
	end

	// Registers; all clear on a power-on reset or in the off state; the sleep bit also clears on wake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `BMC_REG_RST;
			feat <= `BMC_REG_RST;
			wren <= `BMC_REG_RST;
			mon_sel <= 4'h0;
		end else if (ce) begin
			if (clr) begin
				ctrl <= `BMC_REG_RST;
				feat <= `BMC_REG_RST;
				wren <= `BMC_REG_RST;
				mon_sel <= 4'h0;
			end else begin
				// A sleep command in the waking cycle wins, so it is not lost.
				if (sleep_set) ctrl[`BMC_CTRL_SLEEP] <= 1'b1;
				else if (waking) ctrl[`BMC_CTRL_SLEEP] <= 1'b0;
				else if (wr & hit_ctl) ctrl[`BMC_CTRL_SLEEP] <= 1'b0;
				if (feat_wr) feat <= pwdata[7:0] & `BMC_FEAT_MASK;
				if (wr & hit_wren) wren <= pwdata[7:0] & `BMC_WREN_MASK;
				if (wr & hit_mon) mon_sel <= pwdata[3:0];
			end
		end
	end

	// Temperature scan, delayed external and undelayed internal over-temperature compares.
	wire awake = (state == ST_AWAKE);
	wire auto_on = ~feat[`BMC_FEAT_ASD] & (period_cnt < ON_CYC);
	wire manual_on = (mon_sel == `BMC_MON_EXT);
	wire supply_on = awake & (auto_on | manual_on | feat[`BMC_FEAT_FORCE]);
	wire armed = sensor_supply_out & (settle_cnt >= SETTLE);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt <= 23'h0;
			settle_cnt <= 23'h0;
			sensor_supply_out <= 1'b0;
			ext_ot_fail <= 1'b0;
			int_ot_fail <= 1'b0;
		end else if (ce) begin
			if (!awake || period_cnt == PERIOD_CYC - 23'h1) period_cnt <= 23'h0;
			else period_cnt <= period_cnt + 23'h1;
			if (!sensor_supply_out) settle_cnt <= 23'h0;
			else if (settle_cnt < SETTLE) settle_cnt <= settle_cnt + 23'h1;
			sensor_supply_out <= supply_on;
			if (!awake) ext_ot_fail <= 1'b0;
			else if (armed) ext_ot_fail <= pins_b.therm_low;
			int_ot_fail <= awake & pins_b.int_hot;
		end
	end

	// Monitor output steering.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor_select <= 4'h0;
			thermistor_route <= 1'b0;
		end else if (ce) begin
			monitor_select <= awake ? mon_sel : 4'h0;
			thermistor_route <= awake & manual_on;
		end
	end

	// Two-wire bus framing; the device only listens to the master clock.
	wire scl_hi = pins_b.scl & pins_c.scl;
	wire start_det = scl_hi & pins_c.sda & ~pins_b.sda;
	wire stop_det = scl_hi & ~pins_c.sda & pins_b.sda;
	wire scl_rise = pins_b.scl & ~pins_c.scl;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_active <= 1'b0;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			rx_byte <= 8'h00;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			if (start_det) begin
				bus_active <= 1'b1;
				bit_cnt <= 4'h0;
			end else if (stop_det) begin
				bus_active <= 1'b0;
				bit_cnt <= 4'h0;
			end else if (bus_active && scl_rise) begin
				shift <= {shift[6:0], pins_b.sda};
				if (bit_cnt == 4'h8) begin
					bit_cnt <= 4'h0;
				end else begin
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == 4'h7) rx_byte <= {shift[6:0], pins_b.sda};
				end
			end
		end
	end

	assign stat = '{rx_byte: rx_byte, bus_active: bus_active, int_ot: int_ot_fail,
		ext_ot: ext_ot_fail, awake: awake};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_power_up;
		ce && state == ST_OFF && ok;
	endsequence
	property p_power_up;
		s_power_up |=> state == ST_AWAKE && regulator_output == !feat[`BMC_FEAT_REGDIS];
	endproperty
	a_power_up: assert property (p_power_up) else $error("power up missed");
	property p_power_loss;
		ce && !ok |=> state == ST_OFF && !regulator_output;
	endproperty
	a_power_loss: assert property (p_power_loss) else $error("supply loss missed");
	property p_wake;
		ce && state == ST_SLEEP && ok && wake_evt && !sleep_set
			|=> awake && !ctrl[`BMC_CTRL_SLEEP];
	endproperty
	a_wake: assert property (p_wake) else $error("wake failed");
	property p_sleep_held;
		ce && state == ST_SLEEP && ok && !wake_evt |=> state == ST_SLEEP;
	endproperty
	a_sleep_held: assert property (p_sleep_held) else $error("spurious wake");
	property p_auto_scan;
		ce && awake && ok && !feat[`BMC_FEAT_ASD] && period_cnt == 23'h0 |=> sensor_supply_out;
	endproperty
	a_auto_scan: assert property (p_auto_scan) else $error("scan not on");
	property p_force;
		ce && awake && feat[`BMC_FEAT_FORCE] |=> sensor_supply_out;
	endproperty
	a_force: assert property (p_force) else $error("force on ignored");
	property p_manual;
		ce && awake && mon_sel == `BMC_MON_EXT |=> sensor_supply_out && thermistor_route;
	endproperty
	a_manual: assert property (p_manual) else $error("manual scan off");
	property p_no_early_fail;
		ce && awake && $rose(sensor_supply_out) |-> ##1 ($stable(ext_ot_fail) [*3]);
	endproperty
	a_no_early_fail: assert property (p_no_early_fail) else $error("compare too early");
	sequence s_por_write;
		ce && por_req ##1 ce;
	endsequence
	property p_por;
		s_por_write |=> wren == 8'h00 && feat == 8'h00 && mon_sel == 4'h0;
	endproperty
	a_por: assert property (p_por) else $error("por left state");
	property p_start;
		ce && start_det |=> bus_active && bit_cnt == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start missed");
	property p_stop;
		ce && stop_det && !start_det |=> !bus_active;
	endproperty
	a_stop: assert property (p_stop) else $error("stop missed");
	property p_msb;
		ce && bus_active && scl_rise && !start_det && !stop_det && bit_cnt == 4'h7
			|=> rx_byte[0] == $past(pins_b.sda);
	endproperty
	a_msb: assert property (p_msb) else $error("bit order wrong");

endmodule // bmc_control

// File: dv/bmc_two_wire_master.sv
/*
 Model of the pack microcontroller as two-wire bus master.
 Assumes pull-ups on both lines; the bench resolves the wire levels.
 Assumes pclk paces the link: one bit takes eight clock cycles.
*/
`timescale 1ns/1ps
module bmc_two_wire_master (
	input logic pclk,
	output logic scl_oe,
	output logic sda_oe
);
	localparam int QTR = 2;
	localparam int HALF = 4;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic start_c();
		sda_oe <= 1'b1;
		repeat (HALF) @(posedge pclk);
		scl_oe <= 1'b1;
		repeat (QTR) @(posedge pclk);
	endtask
	task automatic send_bit(input logic b);
		sda_oe <= ~b;
		repeat (QTR) @(posedge pclk);
		scl_oe <= 1'b0;
		repeat (HALF) @(posedge pclk);
		scl_oe <= 1'b1;
		repeat (QTR) @(posedge pclk);
	endtask
	task automatic send_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			send_bit(d[i]);
		end
		send_bit(1'b1);
	endtask
	task automatic junk(input logic [7:0] d);
		scl_oe <= 1'b1;
		repeat (HALF) @(posedge pclk);
		send_byte(d);
		scl_oe <= 1'b0;
		repeat (HALF) @(posedge pclk);
	endtask
	task automatic stop_c();
		sda_oe <= 1'b1;
		repeat (QTR) @(posedge pclk);
		scl_oe <= 1'b0;
		repeat (HALF) @(posedge pclk);
		sda_oe <= 1'b0;
		repeat (HALF) @(posedge pclk);
	endtask
endmodule // bmc_two_wire_master

// File: dv/tb_top.sv
/*
 Self-checking bench of the battery monitor control block.
 Assumes the package, constants header and master model are compiled first.
*/
`timescale 1ns/1ps
`include "bmc_consts.svh"
module tb_top;
	import bmc_pkg::*;
	localparam int SON = 20;
	localparam int SPER = 200;
	localparam int SET = 5;
	localparam logic [7:0] A_SEL = {`BMC_IDX_MONSEL, 2'b00};
	localparam logic [7:0] A_CTL = {`BMC_IDX_CTRL, 2'b00};
	localparam logic [7:0] A_FEAT = {`BMC_IDX_FEAT, 2'b00};
	localparam logic [7:0] A_WEN = {`BMC_IDX_WREN, 2'b00};
	localparam logic [7:0] A_STAT = {`BMC_IDX_STAT, 2'b00};
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic cells_ok = 1'b0, wake_pin = 1'b1, thermistor_low = 1'b0, internal_hot = 1'b0;
	logic [7:0] paddr = 8'h00, rx_byte;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, sda_out, sda_oe, regulator_output, sensor_supply_out, err;
	logic thermistor_route, ext_ot_fail, int_ot_fail, bus_active, m_scl_oe, m_sda_oe;
	logic [3:0] monitor_select;
	int miscompares = 0, checked = 0, cyc = 0, n;
	wire scl_in = ~m_scl_oe;
	wire sda_in = ~(m_sda_oe | (sda_oe & ~sda_out));
	always #50 pclk = ~pclk;
	bmc_control #(.SCAN_ON_CYC(SON), .SCAN_PERIOD_CYC(SPER), .SETTLE_CYC(SET)) i_bmc_control (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cells_ok(cells_ok), .wake_pin(wake_pin),
		.thermistor_low(thermistor_low), .internal_hot(internal_hot), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.regulator_output(regulator_output), .sensor_supply_out(sensor_supply_out),
		.thermistor_route(thermistor_route), .monitor_select(monitor_select),
		.ext_ot_fail(ext_ot_fail), .int_ot_fail(int_ot_fail), .rx_byte(rx_byte),
		.bus_active(bus_active));
	bmc_two_wire_master i_bmc_two_wire_master (.pclk(pclk), .scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic cnt(input int len);
		n = 0;
		repeat (len) begin
			@(posedge pclk);
			if (sensor_supply_out === 1'b1) n++;
		end
	endtask
	task automatic wait_reg(input logic v);
		repeat (60) if (regulator_output !== v) @(posedge pclk);
	endtask
	task automatic finish_test();
		if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic t_power();
		chk("reg before", 0, regulator_output);
		cells_ok <= 1'b1;
		wait_reg(1'b1);
		chk("reg on", 1, regulator_output);
		apb(1'b0, A_STAT, 32'h0);
		chk("awake", 1, rd[0]);
		chk("mapped", 0, err);
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped", 1, err);
	endtask
	task automatic t_bus();
		i_bmc_two_wire_master.junk(8'h3c);
		chk("no start", 0, bus_active);
		chk("ignored", 0, rx_byte);
		i_bmc_two_wire_master.start_c();
		i_bmc_two_wire_master.send_byte(8'ha5);
		chk("active", 1, bus_active);
		chk("byte", 8'ha5, rx_byte);
		i_bmc_two_wire_master.stop_c();
		chk("stopped", 0, bus_active);
		chk("sda released", 0, sda_oe);
	endtask
	task automatic t_mux();
		apb(1'b1, A_SEL, 32'h5);
		chk("select", 5, monitor_select);
		thermistor_low <= 1'b1;
		apb(1'b1, A_SEL, `BMC_MON_EXT);
		repeat (SET + 8) @(posedge pclk);
		chk("route", 1, thermistor_route);
		chk("supply", 1, sensor_supply_out);
		chk("ext fail", 1, ext_ot_fail);
		thermistor_low <= 1'b0;
		apb(1'b1, A_SEL, 32'h0);
	endtask
	task automatic t_scan();
		apb(1'b1, A_WEN, 32'h80);
		cnt(SPER);
		chk("scan", SON, n);
		apb(1'b1, A_FEAT, 32'h80);
		repeat (SON) @(posedge pclk);
		cnt(SPER);
		chk("scan off", 0, n);
		apb(1'b1, A_FEAT, 32'ha0);
		cnt(SPER);
		chk("force on", SPER, n);
		chk("ext clear", 0, ext_ot_fail);
		internal_hot <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("int fail", 1, int_ot_fail);
		internal_hot <= 1'b0;
		apb(1'b1, A_FEAT, 32'h0);
	endtask
	task automatic t_freeze();
		ce <= 1'b0;
		internal_hot <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("frozen", 0, int_ot_fail);
		ce <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("thawed", 1, int_ot_fail);
		internal_hot <= 1'b0;
	endtask
	task automatic t_sleep();
		apb(1'b1, A_WEN, 32'h9b);
		apb(1'b1, A_SEL, `BMC_MON_EXT);
		apb(1'b1, A_CTL, 32'h80);
		chk("asleep", 0, regulator_output);
		wake_pin <= 1'b0;
		wait_reg(1'b1);
		chk("fall wake", 1, regulator_output);
		apb(1'b0, A_CTL, 32'h0);
		chk("sleep bit", 0, rd[7:0]);
		chk("select kept", 8, monitor_select);
		apb(1'b0, A_WEN, 32'h0);
		chk("flags", 32'h9b, rd);
		apb(1'b1, A_SEL, 32'h0);
	endtask
	task automatic t_wake_edge_select();
		apb(1'b1, A_FEAT, 32'h01);
		wake_pin <= 1'b1;
		apb(1'b1, A_CTL, 32'h80);
		wake_pin <= 1'b0;
		repeat (20) @(posedge pclk);
		chk("fall ignored", 0, regulator_output);
		wake_pin <= 1'b1;
		wait_reg(1'b1);
		chk("rise wake", 1, regulator_output);
		apb(1'b1, A_FEAT, 32'h43);
		chk("reg disabled", 0, regulator_output);
		apb(1'b1, A_CTL, 32'h80);
		wake_pin <= 1'b0;
		repeat (10) @(posedge pclk);
		wake_pin <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(1'b0, A_STAT, 32'h0);
		chk("wake disabled", 0, rd[0]);
		apb(1'b1, A_FEAT, 32'h01);
		wake_pin <= 1'b0;
		repeat (10) @(posedge pclk);
		wake_pin <= 1'b1;
		wait_reg(1'b1);
		chk("rewake", 1, regulator_output);
	endtask
	task automatic t_por();
		apb(1'b1, A_FEAT, 32'h04);
		apb(1'b0, A_WEN, 32'h0);
		chk("flags cleared", 0, rd);
		apb(1'b0, A_FEAT, 32'h0);
		chk("feature cleared", 0, rd);
	endtask
	task automatic t_loss();
		@(posedge pclk);
		cells_ok <= 1'b0;
		repeat (5) @(posedge pclk);
		chk("supply lost", 0, regulator_output);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_power();
		t_bus();
		t_mux();
		t_scan();
		t_freeze();
		t_sleep();
		t_wake_edge_select();
		t_por();
		t_loss();
		finish_test();
	end
endmodule // tb_top
